/* wake_flow_pkg.sv */
// Constants, register map and command codes for the wake-up and in-band flow block
//
// Functional notes
// [RL1] Parity-mode field all ones selects wake-up operation; parity bit becomes address flag.
// [RL2] Host wake-up, receiver off: queue address characters, drop data characters.
// [RL3] Receiver on in wake-up: every character is queued.
// [RL4] Data bits go to queue data; address flag goes in the parity status slot.
// [RL5] Framing, overrun and break reporting work whether receiver is on or off.
// [RL6] Automatic wake-up: address queueing bit decides if address characters are queued.
// [RL7] Wake-up option field resets to host-controlled wake-up.
// [RL8] Auto-wake: matching address enables receiver; following characters are queued.
// [RL9] Auto-doze: non-matching address disables the receiver.
// [RL10] Address event goes to interrupt arbiter, masked by mask bit 5, with bid level.
// [RL11] Host clears pending address interrupt before enabling a disabled receiver.
// [RL12] Flow enables reset to zero: low bit gates transmitter, high bit inserts characters.
// [RL13] Transparency bit set: flow characters not queued; clear (reset) they are queued.
// [RL14] Auto-transmitter: queued flow-off lets current character finish, then halts transmitter.
// [RL15] Halted transmitter resumes on flow-on or reset; reset flushes transmit queue.
// [RL16] In auto-transmitter mode transmitter commands have no effect.
// [RL17] Halted transmitter still takes writes and reports fill and status.
// [RL18] Break zero character is compared like any received zero character.
// [RL19] Flow character needs queue room; on overrun it is ignored and not queued.
// [RL20] Flow characters with errors still act; their error bits are queued normally.
// [RL21] Auto-receiver sends flow-off above 12 queued, flow-on below 8.
// [RL22] Inserted flow character waits for shifter; queued characters follow it.
// [RL23] Flow character whose fill condition vanishes before starting is cancelled.
// [RL24] Track unrescinded flow-off; clear tracking when auto-receiver enable written zero.
// [RL25] Leaving auto-receiver mode never sends a negating flow-on.
// [RL26] Only characters flagged as address drive wake or doze decisions.
package wake_flow_pkg;

	// Register offsets on the plain register port
	localparam logic [7:0] OFS_MODE_ZERO  = 8'h00;
	localparam logic [7:0] OFS_MODE_ONE   = 8'h01;
	localparam logic [7:0] OFS_ADDR_MATCH = 8'h02;
	localparam logic [7:0] OFS_INT_MASK   = 8'h03;
	localparam logic [7:0] OFS_ADDR_BID   = 8'h04;
	localparam logic [7:0] OFS_COMMAND    = 8'h05;
	localparam logic [7:0] OFS_FLOW_INT   = 8'h06;
	localparam logic [7:0] OFS_XON_CHAR   = 8'h07;
	localparam logic [7:0] OFS_XOFF_CHAR  = 8'h08;
	localparam logic [7:0] OFS_CH_STATUS  = 8'h09;

	// Field positions in mode and mask registers
	localparam int BIT_AUTO_WAKE  = 0;
	localparam int BIT_AUTO_DOZE  = 1;
	localparam int BIT_AUTO_TX    = 2;
	localparam int BIT_AUTO_RX    = 3;
	localparam int BIT_ADDR_QUEUE = 6;
	localparam int BIT_TRANSP     = 7;
	localparam int BIT_PARITY_LO  = 3;
	localparam int BIT_MASK_ADDR  = 5;
	localparam logic [1:0] PARITY_WAKE = 2'h3;

	// Reset values
	localparam logic [7:0] MODE_ZERO_RST = 8'h00;
	localparam logic [7:0] MODE_ONE_RST  = 8'h00;
	localparam logic [7:0] REG_RST       = 8'h00;
	localparam logic [3:0] BID_RST       = 4'h0;
	localparam logic [7:0] XON_RST       = 8'h11;
	localparam logic [7:0] XOFF_RST      = 8'h13;

	// Receive queue levels
	localparam logic [4:0] RXQ_DEPTH  = 5'h10;
	localparam logic [4:0] XOFF_LEVEL = 5'h0c;
	localparam logic [4:0] XON_LEVEL  = 5'h08;

	// Command codes in command_reg[7:4]
	localparam logic [3:0] CMD_NOP      = 4'h0;
	localparam logic [3:0] CMD_RX_EN    = 4'h1;
	localparam logic [3:0] CMD_RX_DIS   = 4'h2;
	localparam logic [3:0] CMD_RX_RST   = 4'h3;
	localparam logic [3:0] CMD_TX_EN    = 4'h4;
	localparam logic [3:0] CMD_TX_DIS   = 4'h5;
	localparam logic [3:0] CMD_CLR_ADDR = 4'h6;
	localparam logic [3:0] CMD_CLR_ERR  = 4'h7;
	localparam logic [3:0] CMD_SW_RST   = 4'h8;

endpackage

/* wake_flow.sv */
// Receive address recognition and in-band flow control for one channel
`timescale 1ns/1ps
module wake_flow
	import wake_flow_pkg::*;
(
	input  wire logic       sys_clk_i,           // 200 MHz clock
	input  wire logic       reset_i,             // Sync reset, active high
	input  wire logic [7:0] reg_addr_i,          // Register address
	input  wire logic [7:0] reg_wdata_i,         // Register write data
	input  wire logic       reg_wr_i,            // Write strobe
	input  wire logic       reg_rd_i,            // Read strobe
	output logic      [7:0] reg_rdata_o,         // Read data, cycle after strobe
	input  wire logic       rx_char_valid_i,     // Received character pulse
	input  wire logic [7:0] rx_char_data_i,      // Received data bits
	input  wire logic       rx_char_ad_i,        // Parity or address flag bit
	input  wire logic       rx_parity_err_i,     // Parity error (normal mode)
	input  wire logic       rx_frame_err_i,      // Framing error
	input  wire logic       rx_break_i,          // Break character (data zero)
	input  wire logic [4:0] rx_queue_fill_i,     // Receive queue fill 0..16
	output logic            rx_push_o,           // Push into rx_queue
	output logic      [7:0] rx_push_data_o,      // Data for rx_queue
	output logic      [3:0] rx_push_status_o,    // {break,frame,parity/ad,overrun slot tied to 0}
	output logic            rx_char_available_o, // Character waiting
	output logic            rx_enabled_o,        // Receiver enabled
	output logic            tx_run_o,            // Transmitter may load next char
	output logic            tx_queue_flush_o,    // Discard tx_queue contents
	output logic            tx_flow_req_o,       // Flow character to insert
	output logic      [7:0] tx_flow_char_o,      // Character to insert
	input  wire logic       tx_flow_start_i,     // Shifter starts flow character
	output logic            addr_bid_o,          // Address event bid to arbiter
	output logic      [3:0] addr_bid_level_o     // Bid level of address event
);

	logic [7:0] mode_zero_q;
	logic [7:0] mode_one_q;
	logic [7:0] addr_match_q;
	logic [7:0] int_mask_q;
	logic [3:0] bid_level_q;
	logic [7:0] xon_char_q;
	logic [7:0] xoff_char_q;
	logic [7:0] rdata_q;
	logic       rx_en_q;
	logic       tx_en_q;
	logic       tx_halt_q;
	logic       addr_int_q;
	logic       xon_seen_q;
	logic       xoff_seen_q;
	logic       overrun_q;
	logic       xoff_sent_q;
	logic       flow_req_q;
	logic [7:0] flow_char_q;
	logic       push_q;
	logic [7:0] push_data_q;
	logic [3:0] push_status_q;
	logic       avail_q;
	logic       flush_q;
	logic       bid_q;
	logic       run_q;

	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	function automatic logic char_eq(input logic [7:0] a, input logic [7:0] b);
		return a == b;
	endfunction

	// Register port decode
	wire       wr_mode0  = reg_wr_i & reg_hit(reg_addr_i, OFS_MODE_ZERO);
	wire       wr_mode1  = reg_wr_i & reg_hit(reg_addr_i, OFS_MODE_ONE);
	wire       wr_match  = reg_wr_i & reg_hit(reg_addr_i, OFS_ADDR_MATCH);
	wire       wr_mask   = reg_wr_i & reg_hit(reg_addr_i, OFS_INT_MASK);
	wire       wr_bid    = reg_wr_i & reg_hit(reg_addr_i, OFS_ADDR_BID);
	wire       wr_cmd    = reg_wr_i & reg_hit(reg_addr_i, OFS_COMMAND);
	wire       wr_xon    = reg_wr_i & reg_hit(reg_addr_i, OFS_XON_CHAR);
	wire       wr_xoff   = reg_wr_i & reg_hit(reg_addr_i, OFS_XOFF_CHAR);
	wire       rd_flow   = reg_rd_i & reg_hit(reg_addr_i, OFS_FLOW_INT);
	wire [3:0] cmd       = wr_cmd ? reg_wdata_i[7:4] : CMD_NOP;
	wire       sw_rst    = cmd == CMD_SW_RST;
	wire       rx_rst    = cmd == CMD_RX_RST;
	wire       clr_addr  = (cmd == CMD_CLR_ADDR) | rd_flow | rx_rst;
	wire       auto_tx   = mode_zero_q[BIT_AUTO_TX];
	wire       auto_rx   = mode_zero_q[BIT_AUTO_RX];
	wire       wake_mode = mode_one_q[BIT_PARITY_LO+1:BIT_PARITY_LO] == PARITY_WAKE; // RL1

	wire [7:0] flow_stat = {3'h0, tx_halt_q, xoff_sent_q, xoff_seen_q, xon_seen_q, addr_int_q};
	wire [7:0] ch_stat   = {3'h0, wake_mode, avail_q, overrun_q, tx_en_q, rx_en_q};

	// Read multiplexer; unmapped offsets read zero
	logic [7:0] rdata_d;
	always_comb begin
		rdata_d = REG_RST;
		if (reg_hit(reg_addr_i, OFS_MODE_ZERO)) begin
			rdata_d = mode_zero_q;
		end else if (reg_hit(reg_addr_i, OFS_MODE_ONE)) begin
			rdata_d = mode_one_q;
		end else if (reg_hit(reg_addr_i, OFS_ADDR_MATCH)) begin
			rdata_d = addr_match_q;
		end else if (reg_hit(reg_addr_i, OFS_INT_MASK)) begin
			rdata_d = int_mask_q;
		end else if (reg_hit(reg_addr_i, OFS_ADDR_BID)) begin
			rdata_d = {4'h0, bid_level_q};
		end else if (reg_hit(reg_addr_i, OFS_FLOW_INT)) begin
			rdata_d = flow_stat;
		end else if (reg_hit(reg_addr_i, OFS_XON_CHAR)) begin
			rdata_d = xon_char_q;
		end else if (reg_hit(reg_addr_i, OFS_XOFF_CHAR)) begin
			rdata_d = xoff_char_q;
		end else if (reg_hit(reg_addr_i, OFS_CH_STATUS)) begin
			rdata_d = ch_stat;
		end
	end

	// Received character classification
	wire auto_wake  = mode_zero_q[BIT_AUTO_WAKE];
	wire auto_doze  = mode_zero_q[BIT_AUTO_DOZE];
	wire auto_mode  = auto_wake | auto_doze;
	wire addr_char  = wake_mode & rx_char_ad_i; // RL26
	wire addr_match = char_eq(rx_char_data_i, addr_match_q);
	wire wake_hit   = rx_char_valid_i & addr_char & auto_wake & addr_match; // RL8
	wire doze_hit   = rx_char_valid_i & addr_char & auto_doze & ~addr_match; // RL9

	// Whether the character is headed for the queue before room and transparency
	logic accept;
	always_comb begin
		accept = rx_en_q;
		if (wake_mode && addr_char) begin
			accept = auto_mode ? mode_zero_q[BIT_ADDR_QUEUE] : 1'b1; // RL2 RL6
		end
	end

	wire room      = rx_queue_fill_i < RXQ_DEPTH;
	wire is_xon    = char_eq(rx_char_data_i, xon_char_q); // RL18
	wire is_xoff   = char_eq(rx_char_data_i, xoff_char_q); // RL18
	wire flow_ok   = rx_char_valid_i & accept & room; // RL19 RL20
	wire xon_hit   = flow_ok & is_xon;
	wire xoff_hit  = flow_ok & is_xoff;
	wire transp    = mode_zero_q[BIT_TRANSP] & (is_xon | is_xoff); // RL13
	wire push_d    = flow_ok & ~transp; // RL3 RL19
	wire overrun_d = rx_char_valid_i & ~room & (accept | wake_mode); // RL5
	wire par_slot  = wake_mode ? rx_char_ad_i : rx_parity_err_i; // RL4

	// Auto-receiver fill thresholds
	wire want_xoff = auto_rx & ~xoff_sent_q & (rx_queue_fill_i > XOFF_LEVEL); // RL21
	wire want_xon  = auto_rx & xoff_sent_q & (rx_queue_fill_i < XON_LEVEL); // RL21 RL25
	wire flow_go   = flow_req_q & tx_flow_start_i;

	// Mode and character registers
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || sw_rst) begin
			mode_zero_q <= MODE_ZERO_RST; // RL7 RL12 RL13
			mode_one_q  <= MODE_ONE_RST;
			addr_match_q <= REG_RST;
			int_mask_q  <= REG_RST;
			bid_level_q <= BID_RST;
			xon_char_q  <= XON_RST;
			xoff_char_q <= XOFF_RST;
		end else begin
			if (wr_mode0) begin
				mode_zero_q <= reg_wdata_i;
			end
			if (wr_mode1) begin
				mode_one_q <= reg_wdata_i;
			end
			if (wr_match) begin
				addr_match_q <= reg_wdata_i;
			end
			if (wr_mask) begin
				int_mask_q <= reg_wdata_i;
			end
			if (wr_bid) begin
				bid_level_q <= reg_wdata_i[3:0];
			end
			if (wr_xon) begin
				xon_char_q <= reg_wdata_i;
			end
			if (wr_xoff) begin
				xoff_char_q <= reg_wdata_i;
			end
		end
	end

	// Receiver enable: host command wins over address comparators
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || sw_rst) begin
			rx_en_q <= 1'b0;
		end else if (cmd == CMD_RX_DIS || rx_rst) begin
			rx_en_q <= 1'b0;
		end else if (cmd == CMD_RX_EN) begin
			rx_en_q <= 1'b1;
		end else if (wake_hit) begin
			rx_en_q <= 1'b1; // RL8
		end else if (doze_hit) begin
			rx_en_q <= 1'b0; // RL9
		end
	end

	// Transmitter gating, next-state values
	logic tx_en_d;
	always_comb begin
		tx_en_d = tx_en_q;
		if (!auto_tx && cmd == CMD_TX_EN) begin
			tx_en_d = 1'b1; // RL16
		end else if (!auto_tx && cmd == CMD_TX_DIS) begin
			tx_en_d = 1'b0; // RL16
		end
	end

	logic tx_halt_d;
	always_comb begin
		tx_halt_d = tx_halt_q;
		if (auto_tx && xoff_hit) begin
			tx_halt_d = 1'b1; // RL14
		end else if (auto_tx && xon_hit) begin
			tx_halt_d = 1'b0; // RL15
		end
	end

	// Run flag registered from next state, so the output is a flop
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || sw_rst) begin
			tx_en_q   <= 1'b0;
			tx_halt_q <= 1'b0; // RL15
			run_q     <= 1'b0;
		end else begin
			tx_en_q   <= tx_en_d;
			tx_halt_q <= tx_halt_d;
			run_q     <= tx_en_d & ~tx_halt_d; // RL14 RL17
		end
	end

	// Sticky status, set wins over clear
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || sw_rst) begin
			addr_int_q  <= 1'b0;
			xon_seen_q  <= 1'b0;
			xoff_seen_q <= 1'b0;
			overrun_q   <= 1'b0;
		end else begin
			addr_int_q  <= (rx_char_valid_i & addr_char) | (addr_int_q & ~clr_addr);
			xon_seen_q  <= xon_hit | (xon_seen_q & ~rd_flow);
			xoff_seen_q <= xoff_hit | (xoff_seen_q & ~rd_flow);
			overrun_q   <= overrun_d | (overrun_q & ~(cmd == CMD_CLR_ERR)); // RL5
		end
	end

	// Flow character insertion and flow-off tracking
	always_ff @(posedge sys_clk_i) begin
		if (reset_i || sw_rst) begin
			xoff_sent_q <= 1'b0;
			flow_req_q  <= 1'b0;
			flow_char_q <= REG_RST;
		end else begin
			flow_req_q  <= want_xoff | want_xon; // RL23
			flow_char_q <= want_xoff ? xoff_char_q : xon_char_q;
			if (wr_mode0 && !reg_wdata_i[BIT_AUTO_RX]) begin
				xoff_sent_q <= 1'b0; // RL24
			end else if (flow_go) begin
				xoff_sent_q <= ~xoff_sent_q; // RL24
			end
		end
	end

	// Queue push, register read and arbiter outputs
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			push_q        <= 1'b0;
			push_data_q   <= REG_RST;
			push_status_q <= 4'h0;
			avail_q       <= 1'b0;
			rdata_q       <= REG_RST;
			flush_q       <= 1'b1;
			bid_q         <= 1'b0;
		end else begin
			push_q        <= push_d; // RL2 RL3
			push_data_q   <= rx_char_data_i; // RL4
			push_status_q <= {rx_break_i, rx_frame_err_i, par_slot, 1'b0}; // RL4 RL20
			avail_q       <= push_d | (avail_q & (rx_queue_fill_i != 5'h00));
			rdata_q       <= reg_rd_i ? rdata_d : REG_RST;
			flush_q       <= sw_rst; // RL15
			bid_q         <= ((rx_char_valid_i & addr_char) | (addr_int_q & ~clr_addr))
				& ~int_mask_q[BIT_MASK_ADDR]; // RL10
		end
	end

	assign reg_rdata_o         = rdata_q;
	assign rx_push_o           = push_q;
	assign rx_push_data_o      = push_data_q;
	assign rx_push_status_o    = push_status_q;
	assign rx_char_available_o = avail_q;
	assign rx_enabled_o        = rx_en_q;
	assign tx_run_o            = run_q; // RL14 RL17
	assign tx_queue_flush_o    = flush_q;
	assign tx_flow_req_o       = flow_req_q; // RL22
	assign tx_flow_char_o      = flow_char_q;
	assign addr_bid_o          = bid_q;
	assign addr_bid_level_o    = bid_level_q; // RL10

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	chk_host_drop_data: assert property ( // RL2
		rx_char_valid_i && wake_mode && !auto_mode && !rx_char_ad_i && !rx_en_q |=> !rx_push_o)
		else $error("data char queued while receiver disabled");
	chk_host_addr_q: assert property ( // RL2
		rx_char_valid_i && wake_mode && !auto_mode && rx_char_ad_i && room && !transp
		|=> rx_push_o && rx_push_status_o[1])
		else $error("address char not queued with flag");
	chk_enabled_all: assert property ( // RL3
		rx_char_valid_i && rx_en_q && !addr_char && room && !transp |=> rx_push_o)
		else $error("enabled receiver dropped character");
	chk_wake_enable: assert property ( // RL8
		rx_char_valid_i && wake_mode && rx_char_ad_i && auto_wake && addr_match
		&& !wr_cmd |=> rx_enabled_o)
		else $error("matching address did not wake receiver");
	chk_doze_disable: assert property ( // RL9
		rx_char_valid_i && wake_mode && rx_char_ad_i && auto_doze && !addr_match
		&& !wr_cmd |=> !rx_enabled_o)
		else $error("foreign address did not doze receiver");
	chk_data_no_wake: assert property ( // RL26
		rx_char_valid_i && !rx_char_ad_i && !rx_en_q && !wr_cmd |=> !rx_enabled_o)
		else $error("data character woke receiver");
	chk_addr_mask: assert property ( // RL10
		int_mask_q[BIT_MASK_ADDR] && $stable(int_mask_q) |=> !addr_bid_o)
		else $error("masked address event reached arbiter");
	chk_addr_bid: assert property ( // RL10
		rx_char_valid_i && addr_char && !int_mask_q[BIT_MASK_ADDR] |=> addr_bid_o)
		else $error("address event did not bid");
	chk_overrun_flag: assert property ( // RL5
		rx_char_valid_i && !room && (rx_en_q || wake_mode) && !sw_rst |=> overrun_q)
		else $error("overrun not recorded");

	// Transmit and flow checks
	chk_xoff_halt: assert property ( // RL14
		auto_tx && xoff_hit && !sw_rst
		|=> !tx_run_o ##1 (!tx_run_o || $past(xon_hit)))
		else $error("flow-off did not halt transmitter");
	chk_xon_resume: assert property ( // RL15
		auto_tx && xon_hit && !xoff_hit && !sw_rst |=> !tx_halt_q)
		else $error("flow-on did not resume transmitter");
	chk_halt_hold: assert property ( // RL15
		tx_halt_q && !xon_hit && !sw_rst |=> tx_halt_q)
		else $error("halted transmitter resumed without flow-on");
	chk_sw_flush: assert property ( // RL15
		sw_rst |=> tx_queue_flush_o && !tx_halt_q)
		else $error("software reset did not flush transmit queue");
	chk_overrun_flow: assert property ( // RL19
		rx_char_valid_i && !room && !sw_rst |=> !rx_push_o && $stable(tx_halt_q))
		else $error("overrun character acted or was queued");
	chk_xoff_request: assert property ( // RL21
		auto_rx && !xoff_sent_q && rx_queue_fill_i > XOFF_LEVEL && !sw_rst
		|=> tx_flow_req_o && tx_flow_char_o == $past(xoff_char_q))
		else $error("flow-off not requested above threshold");
	chk_xon_request: assert property ( // RL21
		auto_rx && xoff_sent_q && rx_queue_fill_i < XON_LEVEL && !sw_rst
		|=> tx_flow_req_o && tx_flow_char_o == $past(xon_char_q))
		else $error("flow-on not requested below threshold");
	chk_cancel_req: assert property ( // RL23
		!auto_rx |=> !tx_flow_req_o)
		else $error("flow request outlived its condition");
	chk_cond_gone: assert property ( // RL23
		auto_rx && !xoff_sent_q && rx_queue_fill_i <= XOFF_LEVEL |=> !tx_flow_req_o)
		else $error("flow-off request without fill condition");
	chk_track_clear: assert property ( // RL24
		wr_mode0 && !reg_wdata_i[BIT_AUTO_RX] |=> !xoff_sent_q ##1 !tx_flow_req_o)
		else $error("flow-off tracking not cleared");
	chk_tx_cmd_ignored: assert property ( // RL16
		auto_tx && wr_cmd && !sw_rst |=> $stable(tx_en_q))
		else $error("transmitter command acted in auto mode");

	cov_auto_wake: cover property (wake_hit ##1 rx_enabled_o ##[1:20] rx_push_o);
	cov_wake_doze: cover property (wake_hit ##[1:200] doze_hit);
	cov_xoff_xon: cover property (flow_go && !xoff_sent_q ##[1:200] flow_go);
	cov_flow_cancel: cover property ((tx_flow_req_o && !xoff_sent_q) ##1
		(!tx_flow_req_o && !xoff_sent_q));
	cov_halt_resume: cover property (tx_halt_q ##[1:100] !tx_halt_q);

endmodule

/* remote_station.sv */
// Far-side model: remote station characters and the local transmit shifter
`timescale 1ns/1ps
module remote_station (
	input  wire logic       sys_clk_i,    // Clock
	input  wire logic       reset_i,      // Sync reset, active high
	input  wire logic       flow_req_i,   // Flow character requested
	input  wire logic       slow_i,       // Late shifter start
	output logic            flow_start_o, // Shifter loads flow char
	output logic            valid_o,      // Character pulse
	output logic      [7:0] data_o,       // Character data
	output logic            ad_o,         // Address flag
	output logic            frame_err_o,  // Framing error
	output logic            break_o       // Break character
);
	logic [2:0] wait_q;
	initial begin
		{valid_o, data_o, ad_o, frame_err_o, break_o} = '0;
	end
	// One character pulse; data and flag lines toggle, error lines clear once it has gone
	task automatic send(input logic [7:0] d, input logic a, input logic f, input logic b);
		@(posedge sys_clk_i);
		valid_o <= 1'b1;
		data_o <= b ? 8'h00 : d;
		ad_o <= a;
		frame_err_o <= f;
		break_o <= b;
		@(posedge sys_clk_i);
		valid_o <= 1'b0;
		data_o <= ~data_o;
		ad_o <= ~ad_o;
		frame_err_o <= 1'b0;
		break_o <= 1'b0;
	endtask
	// Shifter takes the flow char only while it is still requested
	always @(posedge sys_clk_i) begin
		if (reset_i || !flow_req_i || flow_start_o) begin
			wait_q <= 3'h0;
			flow_start_o <= 1'b0;
		end else if (wait_q == (slow_i ? 3'h6 : 3'h1)) begin
			flow_start_o <= 1'b1;
		end else begin
			wait_q <= wait_q + 3'h1;
		end
	end
endmodule

/* tb.sv */
// Self-checking bench for the wake-up and in-band flow block
`timescale 1ns/1ps
module tb;
	import wake_flow_pkg::*;
	logic       sys_clk, reset, wr, rd, perr, slow, start;
	logic [7:0] addr, wdata, rdata, v;
	logic [4:0] fill;
	logic       valid, ad, ferr, brk, push, avail, rx_en, run, flush, req, bid;
	logic [7:0] pdata, fchar, last_data, cdata;
	logic [3:0] pstat, bid_lvl, last_stat;
	int         mismatches, samples_checked, pushes, flushes;

	wake_flow u_wake_flow (.sys_clk_i(sys_clk), .reset_i(reset), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
		.rx_char_valid_i(valid), .rx_char_data_i(cdata),
		.rx_char_ad_i(ad), .rx_parity_err_i(perr), .rx_frame_err_i(ferr),
		.rx_break_i(brk), .rx_queue_fill_i(fill), .rx_push_o(push),
		.rx_push_data_o(pdata), .rx_push_status_o(pstat), .rx_char_available_o(avail),
		.rx_enabled_o(rx_en), .tx_run_o(run), .tx_queue_flush_o(flush),
		.tx_flow_req_o(req), .tx_flow_char_o(fchar), .tx_flow_start_i(start),
		.addr_bid_o(bid), .addr_bid_level_o(bid_lvl));
	remote_station u_remote_station (.sys_clk_i(sys_clk), .reset_i(reset),
		.flow_req_i(req), .slow_i(slow), .flow_start_o(start), .valid_o(valid),
		.data_o(cdata), .ad_o(ad), .frame_err_o(ferr), .break_o(brk));

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// Push and flush monitor
	always @(posedge sys_clk) begin
		if (push === 1'b1) begin
			pushes <= pushes + 1;
			last_data <= pdata;
			last_stat <= pstat;
		end
		if (flush === 1'b1) flushes <= flushes + 1;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic tx(input logic [7:0] d, input logic a, input logic f, input logic b);
		u_remote_station.send(d, a, f, b);
		cyc(3);
	endtask

	task automatic reset_values;
		rreg(8'h00, v); check(v, 8'h00);
		rreg(8'h07, v); check(v, 8'h11);
		rreg(8'h08, v); check(v, 8'h13);
		rreg(8'h2a, v); check(v, 8'h00);
	endtask
	task automatic host_wake;
		int n;
		wreg(8'h01, 8'h18);
		n = pushes;
		tx(8'h42, 1'b0, 1'b0, 1'b0); check(8'(pushes - n), 8'h00);
		tx(8'h42, 1'b1, 1'b1, 1'b0); check(8'(pushes - n), 8'h01);
		check(last_data, 8'h42);
		check({4'h0, last_stat}, 8'h06);
		check({7'h0, avail}, 8'h01);
		wreg(8'h05, 8'h60);
		wreg(8'h05, 8'h10);
		tx(8'h24, 1'b0, 1'b0, 1'b0); check(8'(pushes - n), 8'h02);
	endtask
	task automatic auto_wake;
		int n;
		wreg(8'h05, 8'h20);
		wreg(8'h02, 8'h5a);
		wreg(8'h04, 8'h07);
		wreg(8'h00, 8'h03);
		n = pushes;
		tx(8'h5a, 1'b0, 1'b0, 1'b0); check({7'h0, rx_en}, 8'h00);
		tx(8'h5a, 1'b1, 1'b0, 1'b0); check({7'h0, rx_en}, 8'h01);
		check(8'(pushes - n), 8'h00);
		check({3'h0, bid, bid_lvl}, 8'h17);
		tx(8'h33, 1'b0, 1'b0, 1'b0); check({7'h0, rx_en}, 8'h01);
		check(8'(pushes - n), 8'h01);
		wreg(8'h03, 8'h20); cyc(2); check({7'h0, bid}, 8'h00);
		wreg(8'h00, 8'h43);
		tx(8'h33, 1'b1, 1'b0, 1'b0); check({7'h0, rx_en}, 8'h00);
		check(8'(pushes - n), 8'h02);
		check({4'h0, last_stat}, 8'h02);
		wreg(8'h05, 8'h60);
		wreg(8'h01, 8'h00);
	endtask
	task automatic flow_tx;
		int n;
		wreg(8'h05, 8'h10);
		wreg(8'h05, 8'h40);
		wreg(8'h00, 8'h04); cyc(2); check({7'h0, run}, 8'h01);
		perr <= 1'b1;
		tx(8'h55, 1'b0, 1'b0, 1'b0); check({4'h0, last_stat}, 8'h02);
		perr <= 1'b0;
		n = pushes;
		tx(8'h13, 1'b0, 1'b0, 1'b0); check({7'h0, run}, 8'h00);
		check(8'(pushes - n), 8'h01);
		wreg(8'h05, 8'h50); cyc(2); check({7'h0, run}, 8'h00);
		tx(8'h11, 1'b0, 1'b0, 1'b0); check({7'h0, run}, 8'h01);
		wreg(8'h08, 8'h00);
		tx(8'h77, 1'b0, 1'b1, 1'b1); check({7'h0, run}, 8'h00);
		check({4'h0, last_stat}, 8'h0c);
		wreg(8'h00, 8'h84);
		n = pushes;
		tx(8'h11, 1'b0, 1'b0, 1'b0); check({7'h0, run}, 8'h01);
		check(8'(pushes - n), 8'h00);
		fill <= 5'h10;
		wreg(8'h00, 8'h04);
		tx(8'h00, 1'b0, 1'b0, 1'b0); check({7'h0, run}, 8'h01);
		check(8'(pushes - n), 8'h00);
		rreg(8'h09, v); check(v & 8'h04, 8'h04);
		fill <= 5'h01;
		wreg(8'h08, 8'h13);
		wreg(8'h00, 8'h00);
	endtask
	task automatic flow_rx;
		wreg(8'h00, 8'h08);
		fill <= 5'h0c; cyc(4); check({7'h0, req}, 8'h00);
		fill <= 5'h0d; cyc(3); check({7'h0, req}, 8'h01);
		check(fchar, 8'h13);
		cyc(6); rreg(8'h06, v); check(v & 8'h08, 8'h08);
		fill <= 5'h08; cyc(4); check({7'h0, req}, 8'h00);
		fill <= 5'h07; cyc(3); check({7'h0, req}, 8'h01);
		check(fchar, 8'h11);
		cyc(6); rreg(8'h06, v); check(v & 8'h08, 8'h00);
		slow <= 1'b1;
		fill <= 5'h0d; cyc(3); fill <= 5'h0c; cyc(3);
		check({7'h0, req}, 8'h00);
		cyc(10); rreg(8'h06, v); check(v & 8'h08, 8'h00);
		slow <= 1'b0;
		fill <= 5'h0d; cyc(10);
		rreg(8'h06, v); check(v & 8'h08, 8'h08);
		wreg(8'h00, 8'h00); rreg(8'h06, v); check(v & 8'h08, 8'h00);
		fill <= 5'h07; cyc(8); check({7'h0, req}, 8'h00);
		fill <= 5'h01;
	endtask
	task automatic soft_reset;
		int n;
		n = flushes;
		wreg(8'h05, 8'h80); cyc(3); check(8'(flushes - n), 8'h01);
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		close_out();
	end
	initial begin
		{wr, rd, perr, slow, addr, wdata} = '0;
		{mismatches, samples_checked, pushes, flushes} = '0;
		fill = 5'h01;
		reset = 1'b1;
		cyc(3);
		reset <= 1'b0;
		#1 check({7'h0, flush}, 8'h01);
		reset_values();
		check({7'h0, flush}, 8'h00);
		host_wake();
		auto_wake();
		flow_tx();
		flow_rx();
		soft_reset();
		close_out();
	end
endmodule
